// ### inc/apd_pkg.sv
// Behaviour
// - The reference DAC register is 12 bits wide, bits 11 and 10 read zero and bits 9..0 hold the value, MSB first.
// - Setting a deep, nap or auto-nap enable bit arms that mode on the rising edge of the write strobe.
// - Each power-down mode is left when a later configuration write clears its enable bit.
// - Entering or leaving power-down never changes any configuration field.
// - Starting deep or nap power-down aborts a running conversion so that no result is produced.
// - Deep power-down turns off everything but the digital interface, fully within 2 us.
// - After the deep bit is cleared the device is fully operational again after 1 us.
// - Nap is entered whatever the conversion state, cuts comparator bias within 200 ns while analog bias stays on, and recovers in 6 clocks.
// - Auto-nap naps after each conversion end, wakes on the next trigger within 6 clocks, and is off when its bit clears.
// - A configuration write with address 101 forces the whole device into reset on the write-strobe rising edge.
// - After a software reset the parallel interface is usable again after about 20 ns and must not be used before.
// - The input channel is chosen only by the configuration channel bits, never by a pin.
// - To read the DAC the host writes select 01 address 011, and the next read returns the value on the low bits.
package apd_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int unsigned BUS_W = 12;
    localparam int unsigned DAC_W = 10;
    localparam int unsigned TMR_W = 8;

    // ----------------------------------------
    // Configuration word layout
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] reg_sel;
        logic [2:0] addr;
        logic deep_sleep_enable;
        logic nap_sleep_enable;
        logic auto_sleep_enable;
        logic [1:0] chan_sel;
        logic [1:0] spare;
    } apd_cfg_t;

    localparam logic [1:0] SEL_CFG = 2'h0;
    localparam logic [1:0] SEL_AUX = 2'h1;
    localparam logic [2:0] ADDR_DAC_WR = 3'h1;
    localparam logic [2:0] ADDR_DAC_RD = 3'h3;
    localparam logic [2:0] ADDR_RESET = 3'h5;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [DAC_W-1:0] DAC_RESET = 10'h3ff;
    localparam logic [1:0] DAC_PAD = 2'h0;
    localparam apd_cfg_t CFG_RESET = '0;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned CLK_NS = 8;
    localparam int unsigned DEEP_WAKE_NS = 1000;
    localparam int unsigned SWRST_NS = 20;
    localparam int unsigned NAP_WAKE_CLKS = 6;
    localparam logic [TMR_W-1:0] DEEP_WAKE_CYC = TMR_W'((DEEP_WAKE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TMR_W-1:0] SWRST_CYC = TMR_W'((SWRST_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TMR_W-1:0] NAP_WAKE_CYC = TMR_W'(NAP_WAKE_CLKS);

    // ----------------------------------------
    // Power states
    // ----------------------------------------
    typedef enum logic [2:0] {
        PD_ACTIVE,
        PD_DEEP,
        PD_NAP,
        PD_AUTO,
        PD_WAKE
    } apd_pd_t;

endpackage : apd_pkg

// ### design/apd_timer.sv
`timescale 1ns/10ps
module apd_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Control
    input wire logic load,
    input wire logic [apd_pkg::TMR_W-1:0] load_value,
    // Status
    output logic running,
    output logic expire
);

    logic [apd_pkg::TMR_W-1:0] count;
    logic [apd_pkg::TMR_W-1:0] next_count;
    wire last_tick = running && (count == apd_pkg::TMR_W'(1));

    // ----------------------------------------
    // Down counter
    // ----------------------------------------
    assign next_count = load ? load_value : (running ? count - apd_pkg::TMR_W'(1) : count);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            count <= '0;
            running <= 1'b0;
            expire <= 1'b0;
        end else begin
            count <= next_count;
            running <= load ? (load_value != '0) : (running && !last_tick);
            expire <= !load && last_tick;
        end
    end

endmodule : apd_timer

// ### design/apd_ctrl.sv
`timescale 1ns/10ps
module apd_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Parallel interface
    input wire logic wr_b,
    input wire logic rd_b,
    input wire logic [apd_pkg::BUS_W-1:0] data_in,
    output logic [apd_pkg::BUS_W-1:0] data_out,
    output logic data_oe_b,
    input wire logic conversion_trigger_b,
    // Conversion core
    input wire logic conv_done,
    output logic conv_start,
    output logic conv_abort,
    output logic conv_busy,
    // Analog controls
    output logic analog_bias_en,
    output logic comparator_bias_en,
    output logic [1:0] channel_select,
    output logic [apd_pkg::DAC_W-1:0] dac_value,
    // Status
    output logic interface_ready,
    output logic device_reset
);

    // ----------------------------------------
    // Decoding helpers
    // ----------------------------------------
    function automatic logic is_aux(input apd_pkg::apd_cfg_t w, input logic [2:0] a);
        is_aux = (w.reg_sel == apd_pkg::SEL_AUX) && (w.addr == a);
    endfunction : is_aux

    // ----------------------------------------
    // Strobe edges
    // ----------------------------------------
    logic wr_q;
    logic rd_q;
    logic trig_q;
    logic swrst_run;
    wire wr_rise = !wr_q && wr_b && !swrst_run;
    wire rd_fall = rd_q && !rd_b && !swrst_run;
    wire trig_fall = trig_q && !conversion_trigger_b && !swrst_run;
    wire apd_pkg::apd_cfg_t wr_word = apd_pkg::apd_cfg_t'(data_in);

    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    logic dac_wr_armed;
    logic dac_rd_armed;
    wire data_phase = wr_rise && dac_wr_armed;
    wire ctrl_phase = wr_rise && !dac_wr_armed;
    wire cfg_write = ctrl_phase && (wr_word.reg_sel == apd_pkg::SEL_CFG);
    wire swrst_req = ctrl_phase && (wr_word.addr == apd_pkg::ADDR_RESET);
    wire dac_wr_req = ctrl_phase && is_aux(wr_word, apd_pkg::ADDR_DAC_WR);
    wire dac_rd_req = ctrl_phase && is_aux(wr_word, apd_pkg::ADDR_DAC_RD);

    // Internal reset covers both power-up and the software reset
    logic soft_rst;
    wire core_rst_b = rst_b && !soft_rst;

    // ----------------------------------------
    // Configuration register
    // ----------------------------------------
    apd_pkg::apd_cfg_t cfg;
    apd_pkg::apd_cfg_t next_cfg;
    assign next_cfg = (cfg_write && !swrst_req) ? wr_word : cfg;

    always_ff @(posedge clk) begin
        if (!core_rst_b) begin
            cfg <= apd_pkg::CFG_RESET;
        end else begin
            cfg <= next_cfg;
        end
    end

    // ----------------------------------------
    // Reference DAC register
    // ----------------------------------------
    logic [apd_pkg::DAC_W-1:0] next_dac;
    assign next_dac = data_phase ? data_in[apd_pkg::DAC_W-1:0] : dac_value;

    always_ff @(posedge clk) begin
        if (!core_rst_b) begin
            dac_value <= apd_pkg::DAC_RESET;
            dac_wr_armed <= 1'b0;
            dac_rd_armed <= 1'b0;
        end else begin
            dac_value <= next_dac;
            dac_wr_armed <= wr_rise ? dac_wr_req : dac_wr_armed;
            dac_rd_armed <= wr_rise ? dac_rd_req : (rd_fall ? 1'b0 : dac_rd_armed);
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    logic [apd_pkg::BUS_W-1:0] rd_data;
    logic rd_hold;
    wire [apd_pkg::BUS_W-1:0] dac_word = {apd_pkg::DAC_PAD, dac_value};
    // Configuration readback shows the live power-mode bits untouched by sleep
    wire [apd_pkg::BUS_W-1:0] next_rd_data = rd_fall ? (dac_rd_armed ? dac_word : apd_pkg::BUS_W'(cfg)) : rd_data;

    always_ff @(posedge clk) begin
        if (!core_rst_b) begin
            rd_data <= '0;
            rd_hold <= 1'b0;
        end else begin
            rd_data <= next_rd_data;
            rd_hold <= rd_fall ? 1'b1 : (rd_b ? 1'b0 : rd_hold);
        end
    end

    // ----------------------------------------
    // Timers
    // ----------------------------------------
    logic wake_load;
    logic [apd_pkg::TMR_W-1:0] wake_value;
    logic wake_run;
    logic wake_expire;

    apd_timer u_wake (
        .clk(clk),
        .rst_b(core_rst_b),
        .load(wake_load),
        .load_value(wake_value),
        .running(wake_run),
        .expire(wake_expire)
    );

    apd_timer u_swrst (
        .clk(clk),
        .rst_b(rst_b),
        .load(swrst_req),
        .load_value(apd_pkg::SWRST_CYC),
        .running(swrst_run),
        .expire()
    );

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= swrst_req;
        end
    end

    // ----------------------------------------
    // Power-down state machine
    // ----------------------------------------
    apd_pkg::apd_pd_t pd_state;
    apd_pkg::apd_pd_t next_pd_state;
    logic trig_pend;
    logic next_trig_pend;
    logic start_now;

    wire deep_on = next_cfg.deep_sleep_enable;
    wire nap_on = next_cfg.nap_sleep_enable;
    wire auto_on = next_cfg.auto_sleep_enable;

    always_comb begin
        next_pd_state = pd_state;
        wake_load = 1'b0;
        wake_value = apd_pkg::NAP_WAKE_CYC;
        next_trig_pend = trig_pend;
        start_now = 1'b0;
        case (pd_state)
            apd_pkg::PD_ACTIVE: begin
                if (cfg_write && deep_on) begin
                    next_pd_state = apd_pkg::PD_DEEP;
                end else if (cfg_write && nap_on) begin
                    next_pd_state = apd_pkg::PD_NAP;
                end else if (conv_done && auto_on) begin
                    next_pd_state = apd_pkg::PD_AUTO;
                end else if (trig_fall && !conv_busy) begin
                    start_now = 1'b1;
                end
            end
            apd_pkg::PD_DEEP: begin
                if (cfg_write && !deep_on) begin
                    next_pd_state = apd_pkg::PD_WAKE;
                    wake_load = 1'b1;
                    wake_value = apd_pkg::DEEP_WAKE_CYC;
                end
            end
            apd_pkg::PD_NAP: begin
                if (cfg_write && deep_on) begin
                    next_pd_state = apd_pkg::PD_DEEP;
                end else if (cfg_write && !nap_on) begin
                    next_pd_state = apd_pkg::PD_WAKE;
                    wake_load = 1'b1;
                end
            end
            apd_pkg::PD_AUTO: begin
                if (cfg_write && deep_on) begin
                    next_pd_state = apd_pkg::PD_DEEP;
                end else if (cfg_write && nap_on) begin
                    next_pd_state = apd_pkg::PD_NAP;
                end else if (cfg_write && !auto_on) begin
                    next_pd_state = apd_pkg::PD_WAKE;
                    wake_load = 1'b1;
                end else if (trig_fall) begin
                    next_pd_state = apd_pkg::PD_WAKE;
                    wake_load = 1'b1;
                    next_trig_pend = 1'b1;
                end
            end
            apd_pkg::PD_WAKE: begin
                if (cfg_write && deep_on) begin
                    next_pd_state = apd_pkg::PD_DEEP;
                    next_trig_pend = 1'b0;
                end else if (cfg_write && nap_on) begin
                    next_pd_state = apd_pkg::PD_NAP;
                    next_trig_pend = 1'b0;
                end else if (trig_fall) begin
                    next_trig_pend = 1'b1;
                end else if (wake_expire) begin
                    next_pd_state = apd_pkg::PD_ACTIVE;
                    start_now = trig_pend;
                    next_trig_pend = 1'b0;
                end
            end
            default: begin
                next_pd_state = apd_pkg::PD_ACTIVE;
                next_trig_pend = 1'b0;
            end
        endcase
    end

    // A conversion is aborted whenever deep or nap takes over from a busy core
    wire enter_hard_sleep = (next_pd_state == apd_pkg::PD_DEEP || next_pd_state == apd_pkg::PD_NAP) &&
                            (pd_state != next_pd_state);

    always_ff @(posedge clk) begin
        if (!core_rst_b) begin
            pd_state <= apd_pkg::PD_ACTIVE;
            trig_pend <= 1'b0;
        end else begin
            pd_state <= next_pd_state;
            trig_pend <= next_trig_pend;
        end
    end

    // ----------------------------------------
    // Conversion control
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!core_rst_b) begin
            conv_busy <= 1'b0;
            conv_start <= 1'b0;
            conv_abort <= 1'b0;
        end else begin
            conv_start <= start_now;
            conv_abort <= enter_hard_sleep && conv_busy;
            conv_busy <= start_now ? 1'b1 : ((conv_done || enter_hard_sleep) ? 1'b0 : conv_busy);
        end
    end

    // ----------------------------------------
    // Analog controls and pins
    // ----------------------------------------
    // Biases drop in the very next cycle, far inside either activation limit
    wire next_analog_on = (next_pd_state != apd_pkg::PD_DEEP);
    wire next_comp_on = next_analog_on && (next_pd_state != apd_pkg::PD_NAP) &&
                        (next_pd_state != apd_pkg::PD_AUTO);

    always_ff @(posedge clk) begin
        if (!core_rst_b) begin
            analog_bias_en <= 1'b1;
            comparator_bias_en <= 1'b1;
            channel_select <= apd_pkg::CFG_RESET.chan_sel;
            data_out <= '0;
            data_oe_b <= 1'b1;
        end else begin
            analog_bias_en <= next_analog_on;
            comparator_bias_en <= next_comp_on;
            channel_select <= next_cfg.chan_sel;
            data_out <= next_rd_data;
            data_oe_b <= !(rd_fall || (rd_hold && !rd_b));
        end
    end

    // ----------------------------------------
    // Interface status
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_q <= 1'b1;
            rd_q <= 1'b1;
            trig_q <= 1'b1;
            interface_ready <= 1'b1;
            device_reset <= 1'b0;
        end else begin
            wr_q <= wr_b;
            rd_q <= rd_b;
            trig_q <= conversion_trigger_b;
            interface_ready <= !(swrst_req || swrst_run);
            device_reset <= swrst_req;
        end
    end

endmodule : apd_ctrl

// ### test/apd_core_model.sv
`timescale 1ns/10ps
module apd_core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Core handshake
    input wire logic conv_start,
    input wire logic conv_abort,
    input wire logic [7:0] latency,
    output logic conv_done
);
    // ------
    // Conversion timer
    // ------
    logic [7:0] left;
    // Abort drops the result, so no done pulse follows
    always_ff @(posedge clk) begin
        if (!rst_b || conv_abort) begin
            left <= 8'h00;
        end else if (conv_start) begin
            left <= latency;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end
    assign conv_done = (left == 8'h01);
endmodule : apd_core_model

// ### test/apd_ctrl_props.sv
`timescale 1ns/10ps
module apd_ctrl_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Watched ports
    input wire logic rd_b,
    input wire logic data_oe_b,
    input wire logic conv_start,
    input wire logic conv_abort,
    input wire logic conv_busy,
    input wire logic analog_bias_en,
    input wire logic comparator_bias_en,
    input wire logic [apd_pkg::DAC_W-1:0] dac_value,
    input wire logic interface_ready,
    input wire logic device_reset
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    chk_start_single: assert property (conv_start |=> !conv_start)
        else $error("start pulse too long");
    chk_abort_stops: assert property (conv_abort |=> !conv_abort && !conv_busy)
        else $error("abort left conversion running");
    chk_abort_cause: assert property (conv_abort |-> $past(conv_busy))
        else $error("abort without conversion");
    chk_swrst_window: assert property (device_reset |-> !interface_ready [*4] ##1 interface_ready)
        else $error("reset window length wrong");
    chk_ready_drop: assert property ($fell(interface_ready) |-> device_reset)
        else $error("interface lost without reset");
    chk_swrst_dac: assert property (device_reset |=> dac_value == apd_pkg::DAC_RESET)
        else $error("dac not reset");
    chk_deep_off: assert property (!analog_bias_en |-> !comparator_bias_en)
        else $error("comparator on in deep");
    chk_start_biased: assert property (conv_start |-> analog_bias_en && comparator_bias_en)
        else $error("start while powered down");
    chk_read_release: assert property (rd_b |=> data_oe_b)
        else $error("bus driven after read");
    cov_abort: cover property (conv_abort);
    cov_swrst: cover property (device_reset);
    cov_deep: cover property (!analog_bias_en);
endmodule : apd_ctrl_props

bind apd_ctrl apd_ctrl_props u_props (
    .clk(clk), .rst_b(rst_b), .rd_b(rd_b), .data_oe_b(data_oe_b), .conv_start(conv_start),
    .conv_abort(conv_abort), .conv_busy(conv_busy), .analog_bias_en(analog_bias_en),
    .comparator_bias_en(comparator_bias_en), .dac_value(dac_value),
    .interface_ready(interface_ready), .device_reset(device_reset)
);

// ### test/tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
    $display("MISMATCH %0t got=%h exp=%h", $time, a, e); end end
module tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic wr_b = 1'b1;
    logic rd_b = 1'b1;
    logic conversion_trigger_b = 1'b1;
    logic [11:0] data_in = 12'h000;
    logic [11:0] data_out;
    logic data_oe_b, conv_done, conv_start, conv_abort, conv_busy;
    logic analog_bias_en, comparator_bias_en, interface_ready, device_reset;
    logic [1:0] channel_select;
    logic [1:0] ch;
    logic [9:0] dac_value;
    logic [9:0] v;
    logic [7:0] lat = 8'h04;
    logic [31:0] seed = 32'h99f1f063;
    int bad_count = 0;
    int n_tests = 0;
    int n_abort = 0;
    int n;
    always #4 clk = ~clk;
    always @(posedge clk) if (conv_abort === 1'b1) n_abort++;
    apd_ctrl dut (
        .clk(clk), .rst_b(rst_b), .wr_b(wr_b), .rd_b(rd_b), .data_in(data_in), .data_out(data_out),
        .data_oe_b(data_oe_b), .conversion_trigger_b(conversion_trigger_b), .conv_done(conv_done),
        .conv_start(conv_start), .conv_abort(conv_abort), .conv_busy(conv_busy),
        .analog_bias_en(analog_bias_en), .comparator_bias_en(comparator_bias_en),
        .channel_select(channel_select), .dac_value(dac_value), .interface_ready(interface_ready),
        .device_reset(device_reset)
    );
    apd_core_model core (
        .clk(clk), .rst_b(rst_b), .conv_start(conv_start), .conv_abort(conv_abort), .latency(lat),
        .conv_done(conv_done)
    );
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    function automatic logic [11:0] cfgw(input logic d, input logic p, input logic a, input logic [1:0] c);
        apd_pkg::apd_cfg_t w;
        w = apd_pkg::CFG_RESET;
        w.deep_sleep_enable = d;
        w.nap_sleep_enable = p;
        w.auto_sleep_enable = a;
        w.chan_sel = c;
        return w;
    endfunction : cfgw
    task automatic settle(input int k);
        repeat (k) @(negedge clk);
    endtask : settle
    task automatic wr(input logic [11:0] w);
        @(posedge clk);
        wr_b <= 1'b0;
        data_in <= w;
        @(posedge clk);
        wr_b <= 1'b1;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [11:0] e);
        @(posedge clk);
        rd_b <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        `CHK(data_oe_b, 1'b0)
        `CHK(data_out, e)
        @(posedge clk);
        rd_b <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : rd
    // Trigger moves only on clock edges
    // Counts negedges from trigger release until a start pulse, capped at lim
    task automatic trig(input int lim);
        @(posedge clk);
        conversion_trigger_b <= 1'b0;
        @(posedge clk);
        conversion_trigger_b <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (n < lim && conv_start !== 1'b1);
    endtask : trig
    task automatic final_report;
        if (bad_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        final_report();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        settle(3);
        `CHK(dac_value, apd_pkg::DAC_RESET)
        // ------
        // DAC load and readback, corner values then random
        // ------
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            v = (i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : seed[9:0];
            wr({apd_pkg::SEL_AUX, apd_pkg::ADDR_DAC_WR, 7'h00});
            wr({2'b00, v});
            settle(2);
            `CHK(dac_value, v)
            wr({apd_pkg::SEL_AUX, apd_pkg::ADDR_DAC_RD, 7'h00});
            rd({2'b00, v});
        end
        ch = seed[13:12] | 2'h1;
        wr(cfgw(1'b0, 1'b0, 1'b0, ch));
        settle(2);
        `CHK(channel_select, ch)
        trig(10);
        `CHK(n <= 3, 1'b1)
        settle(8);
        // ------
        // Nap entry aborts a running conversion, recovery holds trigger
        // ------
        lat = 8'h3c;
        trig(10);
        `CHK(conv_busy, 1'b1)
        wr(cfgw(1'b0, 1'b1, 1'b0, ch));
        settle(2);
        `CHK(n_abort, 1)
        `CHK(conv_busy, 1'b0)
        `CHK(comparator_bias_en, 1'b0)
        rd(cfgw(1'b0, 1'b1, 1'b0, ch));
        lat = 8'h04;
        wr(cfgw(1'b0, 1'b0, 1'b0, ch));
        trig(20);
        `CHK(n >= 4 && n <= 12, 1'b1)
        settle(8);
        // Deep: trigger ignored, interface still answers, long wake
        wr(cfgw(1'b1, 1'b0, 1'b0, ch));
        settle(2);
        `CHK(analog_bias_en, 1'b0)
        trig(20);
        `CHK(n, 20)
        rd(cfgw(1'b1, 1'b0, 1'b0, ch));
        wr(cfgw(1'b0, 1'b0, 1'b0, ch));
        trig(200);
        `CHK(n >= 110 && n <= 135, 1'b1)
        `CHK(channel_select, ch)
        settle(8);
        // Auto-nap: nap after done, wake on trigger
        wr(cfgw(1'b0, 1'b0, 1'b1, ch));
        trig(10);
        `CHK(n <= 3, 1'b1)
        settle(12);
        `CHK(comparator_bias_en, 1'b0)
        trig(20);
        `CHK(n >= 6 && n <= 12, 1'b1)
        settle(12);
        wr(cfgw(1'b0, 1'b0, 1'b0, ch));
        settle(10);
        `CHK(comparator_bias_en, 1'b1)
        // Software reset
        wr({apd_pkg::SEL_CFG, apd_pkg::ADDR_RESET, 7'h00});
        n = 0;
        while (device_reset !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        `CHK(interface_ready, 1'b0)
        settle(5);
        `CHK(interface_ready, 1'b1)
        `CHK(channel_select, 2'h0)
        final_report();
    end
endmodule : tb
